// *** dtc_defs.svh ***
// Constants of the dual timer/counter: register addresses, bit positions, resets.
// Assumes it is included by its bare name wherever the constants are used.
`ifndef DTC_DEFS_SVH
`define DTC_DEFS_SVH

// Register addresses on the special function register bus
`define DTC_ADDR_TIMER_CONTROL 8'h88
`define DTC_ADDR_TIMER_MODE_REGISTER 8'h89
`define DTC_ADDR_TL0 8'h8a
`define DTC_ADDR_TL1 8'h8b
`define DTC_ADDR_TH0 8'h8c
`define DTC_ADDR_TH1 8'h8d
`define DTC_ADDR_INTERRUPT_ENABLE_LOW 8'ha8

// Reset values
`define DTC_RST_TIMER_CONTROL 8'h00
`define DTC_RST_TIMER_MODE_REGISTER 8'h00
`define DTC_RST_INTERRUPT_ENABLE_LOW 8'h00
`define DTC_RST_CNT 8'h00
`define DTC_RST_RDATA 8'h00

// Timer control bit positions
`define DTC_TIMER_CONTROL_TF1 7
`define DTC_TIMER_CONTROL_TR1 6
`define DTC_TIMER_CONTROL_TF0 5
`define DTC_TIMER_CONTROL_TR0 4
`define DTC_TIMER_CONTROL_IE1 3
`define DTC_TIMER_CONTROL_IT1 2
`define DTC_TIMER_CONTROL_IE0 1
`define DTC_TIMER_CONTROL_IT0 0

// Mode register fields: timer 0 in the low nibble, timer 1 in the high nibble
`define DTC_TIMER_MODE_REGISTER_GATE1 7
`define DTC_TIMER_MODE_REGISTER_CT1 6
`define DTC_TIMER_MODE_REGISTER_M1_HI 5
`define DTC_TIMER_MODE_REGISTER_M1_LO 4
`define DTC_TIMER_MODE_REGISTER_GATE0 3
`define DTC_TIMER_MODE_REGISTER_CT0 2
`define DTC_TIMER_MODE_REGISTER_M0_HI 1
`define DTC_TIMER_MODE_REGISTER_M0_LO 0

// Interrupt enable bit positions
`define DTC_INTERRUPT_ENABLE_LOW_EAL 7
`define DTC_INTERRUPT_ENABLE_LOW_ET1 3
`define DTC_INTERRUPT_ENABLE_LOW_EX1 2
`define DTC_INTERRUPT_ENABLE_LOW_ET0 1
`define DTC_INTERRUPT_ENABLE_LOW_EX0 0

// Machine cycle length in processor clocks, and the last prescaler count
`define DTC_MC_CLOCKS 12
`define DTC_MC_LAST 4'hb

// Synchronised pin vector positions
`define DTC_PIN_T0 0
`define DTC_PIN_T1 1
`define DTC_PIN_EXTERNAL_IRQ_ZERO_INPUT 2
`define DTC_PIN_INT1 3
`define DTC_PIN_COUNT 4

`endif

// *** dtc_pkg.sv ***
// Types shared by the dual timer/counter modules.
// Assumes dtc_defs.svh is on the include path.
`include "dtc_defs.svh"

package dtc_pkg;

  typedef enum logic [1:0] {
    DTC_MODE_13BIT,
    DTC_MODE_16BIT,
    DTC_MODE_RELOAD,
    DTC_MODE_SPLIT
  } dtc_mode_t;

  typedef struct packed {
    logic [7:0] tl;
    logic [7:0] th;
    logic ovf;
  } dtc_cnt_t;

  typedef struct packed {
    logic [`DTC_PIN_COUNT-1:0] s1;
    logic [`DTC_PIN_COUNT-1:0] s2;
  } dtc_sync_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } dtc_sfr_req_t;

  typedef struct packed {
    logic tmr0_ack;
    logic tmr1_ack;
    logic ext0_ack;
    logic ext1_ack;
  } dtc_ack_t;

  typedef struct packed {
    logic [3:0] tick_cnt;
    logic [7:0] timer_control;
    logic [7:0] timer_mode_register;
    logic [7:0] interrupt_enable_low;
    logic [7:0] tl0;
    logic [7:0] th0;
    logic [7:0] tl1;
    logic [7:0] th1;
    logic [`DTC_PIN_COUNT-1:0] mc_prev;
    logic [`DTC_PIN_COUNT-1:0] clk_prev;
    logic [7:0] rdata;
    logic tmr0_irq;
    logic tmr1_irq;
    logic ext0_irq;
    logic ext1_irq;
    logic tmr1_ovf;
  } dtc_state_t;

endpackage

// *** dtc_pin_sync.sv ***
// Two-flop synchroniser for the external timer and interrupt pins.
// Assumes asynchronous pin levels; output is valid two clocks after a change.
`include "dtc_defs.svh"

module dtc_pin_sync
  import dtc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pins and synchronised levels
  input wire logic [`DTC_PIN_COUNT-1:0] pin_async,
  output logic [`DTC_PIN_COUNT-1:0] pin_sync
);

  dtc_sync_t st_q;
  dtc_sync_t st_d;

  always_comb
  begin
    st_d = st_q;
    st_d.s1 = pin_async;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // Pins idle high, so reset to high: no false low level or edge after reset
      st_q <= '1;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign pin_sync = st_q.s2;

endmodule

// *** dtc_timer_counter.sv ***
// Dual timer/counter with timer control, mode and interrupt enable registers.
// Assumes a byte-wide special function register port from the processor core,
// interrupt acknowledge pulses from the interrupt controller, and raw pins.
`include "dtc_defs.svh"

module dtc_timer_counter
  import dtc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Special function register port
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  // Interrupt service acknowledges
  input wire logic tmr0_irq_ack,
  input wire logic tmr1_irq_ack,
  input wire logic ext0_irq_ack,
  input wire logic ext1_irq_ack,
  // External pins
  input wire logic tmr0_count_pin,
  input wire logic tmr1_count_pin,
  input wire logic external_irq_zero_input,
  input wire logic external_irq_one_input,
  // Interrupt requests and baud rate tick
  output logic tmr0_irq_req,
  output logic tmr1_irq_req,
  output logic ext0_irq_req,
  output logic ext1_irq_req,
  output logic tmr1_baud_tick
);

  dtc_state_t st_q;
  dtc_state_t st_d;
  dtc_sfr_req_t req;
  dtc_ack_t ack;
  logic [`DTC_PIN_COUNT-1:0] pin_s;

  dtc_pin_sync u_pin_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin_async({external_irq_one_input, external_irq_zero_input,
                tmr1_count_pin, tmr0_count_pin}),
    .pin_sync(pin_s)
  );

  assign req = '{addr: sfr_addr, wdata: sfr_wdata, wr: sfr_wr, rd: sfr_rd};
  assign ack = '{tmr0_ack: tmr0_irq_ack, tmr1_ack: tmr1_irq_ack,
                 ext0_ack: ext0_irq_ack, ext1_ack: ext1_irq_ack};

  // One increment of a timer in the given mode
  function automatic dtc_cnt_t cnt_step(input dtc_mode_t mode, input logic [7:0] tl,
                                        input logic [7:0] th);
    dtc_cnt_t r;
    r.tl = tl;
    r.th = th;
    r.ovf = 1'b0;
    case (mode)
      DTC_MODE_13BIT:
      begin
        // Low five bits prescale; upper three low-byte bits are left alone
        r.tl[4:0] = tl[4:0] + 5'h01;
        if (tl[4:0] == 5'h1f)
        begin
          r.th = th + 8'h01;
          r.ovf = (th == 8'hff);
        end
      end
      DTC_MODE_16BIT:
      begin
        {r.th, r.tl} = {th, tl} + 16'h0001;
        r.ovf = ({th, tl} == 16'hffff);
      end
      DTC_MODE_RELOAD:
      begin
        if (tl == 8'hff)
        begin
          r.tl = th;
          r.ovf = 1'b1;
        end
        else
        begin
          r.tl = tl + 8'h01;
        end
      end
      default:
      begin
        // Split low byte: plain 8-bit counter
        r.tl = tl + 8'h01;
        r.ovf = (tl == 8'hff);
      end
    endcase
    return r;
  endfunction

  always_comb
  begin
    logic tick;
    logic [`DTC_PIN_COUNT-1:0] fall;
    dtc_mode_t mode0;
    dtc_mode_t mode1;
    logic split0;
    logic gate_ok0;
    logic gate_ok1;
    logic en0;
    logic en1;
    logic en_th0;
    dtc_cnt_t c0;
    dtc_cnt_t c1;
    logic [7:0] th0_next;
    logic th0_ovf;
    logic set_tf0;
    logic set_tf1;
    logic [7:0] timer_control;
    logic [7:0] rd_mux;
    tick = 1'b0;
    fall = '0;
    mode0 = DTC_MODE_13BIT;
    mode1 = DTC_MODE_13BIT;
    split0 = 1'b0;
    gate_ok0 = 1'b0;
    gate_ok1 = 1'b0;
    en0 = 1'b0;
    en1 = 1'b0;
    en_th0 = 1'b0;
    c0 = '0;
    c1 = '0;
    th0_next = 8'h00;
    th0_ovf = 1'b0;
    set_tf0 = 1'b0;
    set_tf1 = 1'b0;
    timer_control = 8'h00;
    rd_mux = 8'h00;
    st_d = st_q;

    // Machine cycle prescaler
    tick = (st_q.tick_cnt == `DTC_MC_LAST);
    st_d.tick_cnt = tick ? 4'h0 : st_q.tick_cnt + 4'h1;

    // Pins are sampled once per machine cycle; a high then low pair is an edge
    if (tick)
    begin
      st_d.mc_prev = pin_s;
    end
    fall = {`DTC_PIN_COUNT{tick}} & st_q.mc_prev & ~pin_s;

    mode0 = dtc_mode_t'(st_q.timer_mode_register[`DTC_TIMER_MODE_REGISTER_M0_HI:`DTC_TIMER_MODE_REGISTER_M0_LO]);
    mode1 = dtc_mode_t'(st_q.timer_mode_register[`DTC_TIMER_MODE_REGISTER_M1_HI:`DTC_TIMER_MODE_REGISTER_M1_LO]);
    split0 = (mode0 == DTC_MODE_SPLIT);

    // Gate: pass when gate option clear or the interrupt pin is high
    gate_ok0 = !st_q.timer_mode_register[`DTC_TIMER_MODE_REGISTER_GATE0] || pin_s[`DTC_PIN_EXTERNAL_IRQ_ZERO_INPUT];
    gate_ok1 = !st_q.timer_mode_register[`DTC_TIMER_MODE_REGISTER_GATE1] || pin_s[`DTC_PIN_INT1];

    // Timer 0, or the split low byte, under timer 0 controls
    en0 = st_q.timer_control[`DTC_TIMER_CONTROL_TR0] && gate_ok0
          && (st_q.timer_mode_register[`DTC_TIMER_MODE_REGISTER_CT0] ? fall[`DTC_PIN_T0] : tick);

    // Timer 1: its run bit is taken by the split high byte, so it free-runs
    // unless parked in its own mode 3
    if (split0)
    begin
      en1 = gate_ok1
            && (st_q.timer_mode_register[`DTC_TIMER_MODE_REGISTER_CT1] ? fall[`DTC_PIN_T1] : tick);
    end
    else
    begin
      en1 = st_q.timer_control[`DTC_TIMER_CONTROL_TR1] && gate_ok1
            && (st_q.timer_mode_register[`DTC_TIMER_MODE_REGISTER_CT1] ? fall[`DTC_PIN_T1] : tick);
    end
    if (mode1 == DTC_MODE_SPLIT)
    begin
      en1 = 1'b0;
    end

    // Split high byte counts machine cycles on timer 1 run bit
    en_th0 = split0 && st_q.timer_control[`DTC_TIMER_CONTROL_TR1] && tick;

    c0 = cnt_step(mode0, st_q.tl0, st_q.th0);
    c1 = cnt_step(mode1, st_q.tl1, st_q.th1);
    th0_next = st_q.th0 + 8'h01;
    th0_ovf = en_th0 && (st_q.th0 == 8'hff);

    if (en0)
    begin
      st_d.tl0 = c0.tl;
      if (!split0)
      begin
        st_d.th0 = c0.th;
      end
    end
    if (en_th0)
    begin
      st_d.th0 = th0_next;
    end
    if (en1)
    begin
      st_d.tl1 = c1.tl;
      st_d.th1 = c1.th;
    end

    set_tf0 = en0 && c0.ovf;
    set_tf1 = split0 ? th0_ovf : (en1 && c1.ovf);
    st_d.tmr1_ovf = en1 && c1.ovf;

    // Software writes to the counting registers win over the count
    if (req.wr)
    begin
      case (req.addr)
        `DTC_ADDR_TIMER_MODE_REGISTER: st_d.timer_mode_register = req.wdata;
        `DTC_ADDR_TL0: st_d.tl0 = req.wdata;
        `DTC_ADDR_TH0: st_d.th0 = req.wdata;
        `DTC_ADDR_TL1: st_d.tl1 = req.wdata;
        `DTC_ADDR_TH1: st_d.th1 = req.wdata;
        `DTC_ADDR_INTERRUPT_ENABLE_LOW: st_d.interrupt_enable_low = req.wdata;
        default: st_d.interrupt_enable_low = st_d.interrupt_enable_low;
      endcase
    end

    // Control register: clears first, then hardware sets, so a set is never lost
    timer_control = st_q.timer_control;
    if (ack.tmr0_ack)
    begin
      timer_control[`DTC_TIMER_CONTROL_TF0] = 1'b0;
    end
    if (ack.tmr1_ack)
    begin
      timer_control[`DTC_TIMER_CONTROL_TF1] = 1'b0;
    end
    if (ack.ext0_ack && st_q.timer_control[`DTC_TIMER_CONTROL_IT0])
    begin
      timer_control[`DTC_TIMER_CONTROL_IE0] = 1'b0;
    end
    if (ack.ext1_ack && st_q.timer_control[`DTC_TIMER_CONTROL_IT1])
    begin
      timer_control[`DTC_TIMER_CONTROL_IE1] = 1'b0;
    end
    if (req.wr && (req.addr == `DTC_ADDR_TIMER_CONTROL))
    begin
      timer_control = req.wdata;
    end
    if (set_tf0)
    begin
      timer_control[`DTC_TIMER_CONTROL_TF0] = 1'b1;
    end
    if (set_tf1)
    begin
      timer_control[`DTC_TIMER_CONTROL_TF1] = 1'b1;
    end

    // External interrupt flags: edge type latches a falling edge, level type
    // follows the inverted pin
    st_d.clk_prev = pin_s;
    if (timer_control[`DTC_TIMER_CONTROL_IT0])
    begin
      if (st_q.clk_prev[`DTC_PIN_EXTERNAL_IRQ_ZERO_INPUT] && !pin_s[`DTC_PIN_EXTERNAL_IRQ_ZERO_INPUT])
      begin
        timer_control[`DTC_TIMER_CONTROL_IE0] = 1'b1;
      end
    end
    else
    begin
      timer_control[`DTC_TIMER_CONTROL_IE0] = !pin_s[`DTC_PIN_EXTERNAL_IRQ_ZERO_INPUT];
    end
    if (timer_control[`DTC_TIMER_CONTROL_IT1])
    begin
      if (st_q.clk_prev[`DTC_PIN_INT1] && !pin_s[`DTC_PIN_INT1])
      begin
        timer_control[`DTC_TIMER_CONTROL_IE1] = 1'b1;
      end
    end
    else
    begin
      timer_control[`DTC_TIMER_CONTROL_IE1] = !pin_s[`DTC_PIN_INT1];
    end
    st_d.timer_control = timer_control;

    // Requests follow the updated flags through the enables
    st_d.tmr0_irq = st_d.interrupt_enable_low[`DTC_INTERRUPT_ENABLE_LOW_EAL] && st_d.interrupt_enable_low[`DTC_INTERRUPT_ENABLE_LOW_ET0]
                    && st_d.timer_control[`DTC_TIMER_CONTROL_TF0];
    st_d.tmr1_irq = st_d.interrupt_enable_low[`DTC_INTERRUPT_ENABLE_LOW_EAL] && st_d.interrupt_enable_low[`DTC_INTERRUPT_ENABLE_LOW_ET1]
                    && st_d.timer_control[`DTC_TIMER_CONTROL_TF1];
    st_d.ext0_irq = st_d.interrupt_enable_low[`DTC_INTERRUPT_ENABLE_LOW_EAL] && st_d.interrupt_enable_low[`DTC_INTERRUPT_ENABLE_LOW_EX0]
                    && st_d.timer_control[`DTC_TIMER_CONTROL_IE0];
    st_d.ext1_irq = st_d.interrupt_enable_low[`DTC_INTERRUPT_ENABLE_LOW_EAL] && st_d.interrupt_enable_low[`DTC_INTERRUPT_ENABLE_LOW_EX1]
                    && st_d.timer_control[`DTC_TIMER_CONTROL_IE1];

    // Read data registered one clock after the read strobe
    case (req.addr)
      `DTC_ADDR_TIMER_CONTROL: rd_mux = st_q.timer_control;
      `DTC_ADDR_TIMER_MODE_REGISTER: rd_mux = st_q.timer_mode_register;
      `DTC_ADDR_TL0: rd_mux = st_q.tl0;
      `DTC_ADDR_TH0: rd_mux = st_q.th0;
      `DTC_ADDR_TL1: rd_mux = st_q.tl1;
      `DTC_ADDR_TH1: rd_mux = st_q.th1;
      `DTC_ADDR_INTERRUPT_ENABLE_LOW: rd_mux = st_q.interrupt_enable_low;
      default: rd_mux = 8'h00;
    endcase
    if (req.rd)
    begin
      st_d.rdata = rd_mux;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= '0;
      st_q.timer_control <= `DTC_RST_TIMER_CONTROL;
      st_q.timer_mode_register <= `DTC_RST_TIMER_MODE_REGISTER;
      st_q.interrupt_enable_low <= `DTC_RST_INTERRUPT_ENABLE_LOW;
      st_q.tl0 <= `DTC_RST_CNT;
      st_q.th0 <= `DTC_RST_CNT;
      st_q.tl1 <= `DTC_RST_CNT;
      st_q.th1 <= `DTC_RST_CNT;
      st_q.rdata <= `DTC_RST_RDATA;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign sfr_rdata = st_q.rdata;
  assign tmr0_irq_req = st_q.tmr0_irq;
  assign tmr1_irq_req = st_q.tmr1_irq;
  assign ext0_irq_req = st_q.ext0_irq;
  assign ext1_irq_req = st_q.ext1_irq;
  assign tmr1_baud_tick = st_q.tmr1_ovf;

endmodule

// *** dtc_tc_chk.sv ***
// Port-level checker for the dual timer/counter.
// Assumes the prescaler runs freely from reset release, one tick per 12 clocks.
module dtc_tc_chk
  import dtc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata,
  // Interrupt side
  input wire logic tmr0_irq_ack,
  input wire logic tmr1_irq_ack,
  input wire logic tmr0_irq_req,
  input wire logic tmr1_irq_req,
  input wire logic ext0_irq_req,
  input wire logic ext1_irq_req,
  input wire logic tmr1_baud_tick
);
  logic [7:0] ien_q;
  logic [3:0] ph_q;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Shadow of the enables and of the machine-cycle phase
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ien_q <= 8'h00;
      ph_q <= 4'h0;
    end
    else
    begin
      if (sfr_wr && sfr_addr == 8'ha8)
        ien_q <= sfr_wdata;
      ph_q <= (ph_q == 4'hb) ? 4'h0 : ph_q + 4'h1;
    end
  end

  sequence s_quiet;
    !tmr1_baud_tick [*8] ##1 !tmr1_baud_tick [*3];
  endsequence
  property p_tick_gap;
    tmr1_baud_tick |=> s_quiet;
  endproperty
  property p_tick_phase;
    tmr1_baud_tick |-> ph_q inside {4'h0, 4'h1};
  endproperty
  property p_irq0_phase;
    $rose(tmr0_irq_req) && $past(ien_q[7] && ien_q[1], 2) |-> ph_q inside {4'h0, 4'h1};
  endproperty
  property p_eal;
    !ien_q[7] && $past(!ien_q[7]) |-> !(tmr0_irq_req || tmr1_irq_req || ext0_irq_req
      || ext1_irq_req);
  endproperty
  property p_et0;
    !ien_q[1] && $past(!ien_q[1]) |-> !tmr0_irq_req;
  endproperty
  property p_et1;
    !ien_q[3] && $past(!ien_q[3]) |-> !tmr1_irq_req;
  endproperty
  property p_ack0;
    tmr0_irq_ack |=> !tmr0_irq_req;
  endproperty
  property p_ack1;
    tmr1_irq_ack |=> !tmr1_irq_req;
  endproperty
  property p_unmapped;
    sfr_rd && sfr_addr == 8'h80 |=> sfr_rdata == 8'h00;
  endproperty

  a_tick_gap: assert property (p_tick_gap)
    else $error("baud ticks closer than one machine cycle");
  a_tick_phase: assert property (p_tick_phase)
    else $error("baud tick off the machine cycle boundary");
  a_irq0_phase: assert property (p_irq0_phase)
    else $error("timer 0 request rose off the machine cycle boundary");
  a_eal: assert property (p_eal)
    else $error("request raised with global enable low");
  a_et0: assert property (p_et0)
    else $error("timer 0 request raised with its enable low");
  a_et1: assert property (p_et1)
    else $error("timer 1 request raised with its enable low");
  a_ack0: assert property (p_ack0)
    else $error("timer 0 request survived service");
  a_ack1: assert property (p_ack1)
    else $error("timer 1 request survived service");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read returned nonzero");
endmodule

bind dtc_timer_counter dtc_tc_chk dtc_tc_chk_i (.clk, .rst_n, .sfr_addr, .sfr_wdata, .sfr_wr,
  .sfr_rd, .sfr_rdata, .tmr0_irq_ack, .tmr1_irq_ack, .tmr0_irq_req, .tmr1_irq_req,
  .ext0_irq_req, .ext1_irq_req, .tmr1_baud_tick);

// *** dtc_cpu_model.sv ***
// Processor model: single-cycle register writes and reads.
// Assumes each task is entered just after a rising clock edge.
module dtc_cpu_model
  import dtc_pkg::*;
(
  // Clock
  input wire logic clk,
  // Register port
  output logic [7:0] sfr_addr,
  output logic [7:0] sfr_wdata,
  output logic sfr_wr,
  output logic sfr_rd,
  input wire logic [7:0] sfr_rdata
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
  end

  // Idle bus shows the inverse of the last value, never a stale copy
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
    sfr_addr <= ~a;
    sfr_wdata <= ~d;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    sfr_addr <= ~a;
    @(posedge clk);
    d = sfr_rdata;
  endtask
endmodule

// *** dtc_tb.sv ***
// Self-checking bench for the dual timer/counter.
// Assumes the checker is bound in and the processor model owns the register port.
module testbench
  import dtc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
  logic sfr_wr, sfr_rd, tmr0_irq_req, tmr1_irq_req, ext0_irq_req, ext1_irq_req, tmr1_baud_tick;
  logic tmr0_irq_ack = 1'b0;
  logic tmr1_irq_ack = 1'b0;
  logic ext0_irq_ack = 1'b0;
  logic ext1_irq_ack = 1'b0;
  logic tmr0_count_pin = 1'b1;
  logic tmr1_count_pin = 1'b1;
  logic external_irq_zero_input = 1'b1;
  logic external_irq_one_input = 1'b1;
  logic [7:0] mid;
  int errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int nb;

  dtc_cpu_model dtc_cpu_model_i (.clk, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata);
  dtc_timer_counter dtc_timer_counter_i (.clk, .rst_n, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd,
    .sfr_rdata, .tmr0_irq_ack, .tmr1_irq_ack, .ext0_irq_ack, .ext1_irq_ack, .tmr0_count_pin,
    .tmr1_count_pin, .external_irq_zero_input, .external_irq_one_input, .tmr0_irq_req,
    .tmr1_irq_req, .ext0_irq_req, .ext1_irq_req, .tmr1_baud_tick);

  always #50 clk = ~clk;

  task automatic end_of_test();
    if (errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      end_of_test();
    end
  end

  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    dtc_cpu_model_i.wr(a, d);
  endtask

  task automatic rc(input string n, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    dtc_cpu_model_i.rd(a, d);
    chk(n, d, e);
  endtask

  // Gate window of exactly n machine cycles; the pin delay cancels out
  task automatic gate0(input int n);
    external_irq_zero_input <= 1'b1;
    repeat (12 * n) @(posedge clk);
    external_irq_zero_input <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task automatic toggle0(input int n);
    repeat (n)
    begin
      tmr0_count_pin <= 1'b0;
      repeat (24) @(posedge clk);
      tmr0_count_pin <= 1'b1;
      repeat (24) @(posedge clk);
    end
  endtask

  task automatic t_regs();
    rc("control", 8'h88, 8'h00);
    rc("enables", 8'ha8, 8'h00);
    wr(8'h80, 8'hff);
    rc("unmapped", 8'h80, 8'h00);
    wr(8'ha8, 8'h82);
    rc("enables", 8'ha8, 8'h82);
  endtask

  task automatic t_modes();
    external_irq_zero_input <= 1'b0;
    wr(8'h89, 8'h09);
    wr(8'h8a, 8'hfe);
    wr(8'h8c, 8'hff);
    wr(8'h88, 8'h11);
    gate0(3);
    rc("t0 low", 8'h8a, 8'h01);
    rc("t0 high", 8'h8c, 8'h00);
    rc("control", 8'h88, 8'h33);
    chk("t0 req", {7'h00, tmr0_irq_req}, 8'h01);
    tmr0_irq_ack <= 1'b1;
    @(posedge clk);
    tmr0_irq_ack <= 1'b0;
    @(posedge clk);
    rc("control", 8'h88, 8'h13);
    wr(8'h8a, 8'hfe);
    wr(8'h8c, 8'hff);
    wr(8'h89, 8'h08);
    gate0(2);
    rc("t0 low", 8'h8a, 8'he0);
    rc("t0 high", 8'h8c, 8'h00);
    wr(8'h89, 8'h0a);
    wr(8'h8a, 8'hfe);
    wr(8'h8c, 8'hc0);
    gate0(3);
    rc("t0 low", 8'h8a, 8'hc1);
    rc("t0 high", 8'h8c, 8'hc0);
  endtask

  task automatic t_count();
    wr(8'h8a, 8'h00);
    wr(8'h8c, 8'h00);
    wr(8'h89, 8'h05);
    toggle0(3);
    rc("t0 low", 8'h8a, 8'h03);
    wr(8'h88, 8'h00);
    toggle0(1);
    rc("t0 low", 8'h8a, 8'h03);
  endtask

  task automatic t_split();
    wr(8'h89, 8'h3b);
    wr(8'h8a, 8'hfe);
    wr(8'h8c, 8'hff);
    wr(8'h8b, 8'h00);
    wr(8'h88, 8'h11);
    gate0(2);
    rc("t0 low", 8'h8a, 8'h00);
    rc("control", 8'h88, 8'h33);
    wr(8'h89, 8'h37);
    wr(8'h88, 8'h40);
    repeat (20) @(posedge clk);
    dtc_cpu_model_i.rd(8'h88, mid);
    wr(8'h88, 8'h00);
    chk("t1 flag and run", {mid[7:6], 6'h00}, 8'hc0);
    rc("t0 high", 8'h8c, 8'h01);
    rc("t0 low", 8'h8a, 8'h00);
    rc("t1 low", 8'h8b, 8'h00);
    wr(8'h8d, 8'hff);
    wr(8'h8b, 8'hff);
    wr(8'h89, 8'h27);
    repeat (12) @(posedge clk);
    nb = 0;
    repeat (48)
    begin
      @(posedge clk);
      nb += tmr1_baud_tick;
    end
    chk("baud ticks", nb[7:0], 8'h04);
    rc("control", 8'h88, 8'h02);
  endtask

  task automatic t_irq1();
    wr(8'ha8, 8'h08);
    wr(8'h89, 8'h20);
    wr(8'h88, 8'h40);
    repeat (30) @(posedge clk);
    wr(8'h89, 8'h30);
    chk("t1 req", {7'h00, tmr1_irq_req}, 8'h00);
    rc("control", 8'h88, 8'hc2);
    wr(8'ha8, 8'h88);
    repeat (2) @(posedge clk);
    chk("t1 req", {7'h00, tmr1_irq_req}, 8'h01);
    wr(8'ha8, 8'h80);
    repeat (2) @(posedge clk);
    chk("t1 req", {7'h00, tmr1_irq_req}, 8'h00);
    tmr1_irq_ack <= 1'b1;
    @(posedge clk);
    tmr1_irq_ack <= 1'b0;
    @(posedge clk);
    rc("control", 8'h88, 8'h42);
    wr(8'h88, 8'h00);
    wr(8'h8b, 8'h05);
    wr(8'h89, 8'h10);
    repeat (36) @(posedge clk);
    rc("t1 low", 8'h8b, 8'h05);
    wr(8'h89, 8'h30);
    wr(8'h88, 8'h40);
    repeat (36) @(posedge clk);
    rc("t1 low", 8'h8b, 8'h05);
    wr(8'ha8, 8'h85);
    chk("ext0 req", {7'h00, ext0_irq_req}, 8'h01);
    chk("ext1 req", {7'h00, ext1_irq_req}, 8'h00);
    wr(8'ha8, 8'h05);
    chk("ext0 req", {7'h00, ext0_irq_req}, 8'h00);
  endtask

  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_modes();
    t_count();
    t_split();
    t_irq1();
    end_of_test();
  end
endmodule
